// file: rtl/srpdm_pkg.sv
// Constants and register layout of the serial register port with dual memory
// Summary of operation
// - The serial output is driven only while chip select is low and floats while it is high.
// - The port is active only while chip select is low, and the serial clock times every bit on both data lines.
// - One command bit is sampled from the serial input on each rising serial clock edge.
// - The serial output moves to its next response bit on each falling serial clock edge.
// - The serial output carries only the data that an earlier read command asked for.
// - Each 16-bit register has an upper and a lower byte address and is named by its lower one.
// - Working registers steer operation and take all writes, and backed ones also keep a nonvolatile copy.
// - Backed configuration is written to the nonvolatile copy only on bit 12 of global_command_reg (frame 0xbf10).
// - After power-on or any reset the nonvolatile copy loads into the volatile registers before data is produced.
// - Samples get offset adjustment, filtering and alarm checks, then are captured and served through the port.
// - The link is clock polarity 1, phase 1, most significant bit first, 16-bit frames.
// - A read takes two frames: a clear flag with the address, then the data returns during the next frame.
// - A write frame writes one byte: set flag, 7-bit byte address, 8 data bits.
package srpdm_pkg;

  localparam int          FRAME_BITS   = 16;
  localparam int          REG_COUNT    = 32;
  localparam logic [3:0]  BIT_LAST     = 4'hf;

  // Frame layout
  localparam int          FR_RW        = 15;
  localparam int          FR_ADDR_HI   = 14;
  localparam int          FR_ADDR_LO   = 8;
  localparam int          FR_BYTE_SEL  = 8;
  localparam int          FR_IDX_HI    = 13;
  localparam int          FR_IDX_LO    = 9;

  // Register indices (byte address divided by two)
  localparam logic [4:0]  IDX_FLASH_CNT = 5'h00;
  localparam logic [4:0]  IDX_OFFS_X    = 5'h01;
  localparam logic [4:0]  IDX_PEAK_X    = 5'h07;
  localparam logic [4:0]  IDX_BUFF_X    = 5'h0a;
  localparam logic [4:0]  IDX_ALM_X     = 5'h10;
  localparam logic [4:0]  IDX_AVG       = 5'h1c;
  localparam logic [4:0]  IDX_DIAG      = 5'h1e;
  localparam logic [4:0]  IDX_GLOBAL_COMMAND_REG  = 5'h1f;

  // global_command_reg fields
  localparam int          CMD_RELOAD_BIT = 7;
  localparam int          CMD_SAVE_BIT   = 12;

  localparam logic [31:0] BACKUP_MASK   = 32'h5a1f_c3ef;
  localparam logic [31:0] WRITE_MASK    = 32'h9e1f_e00e;
  localparam logic [15:0] CAPT_DEFAULT  = 16'h8000;

  // Minimum inter-frame gap, given in tenths of a microsecond and rounded up to whole clocks
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          STALL_US_X10  = 154;
  localparam int          STALL_CYCLES  = (STALL_US_X10 * 100000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Values after power-on and after a reload of an unbacked register
  function automatic logic [15:0] reg_default(input int idx);
    if (idx >= 5 && idx <= 12)
      return CAPT_DEFAULT;
    else if (idx == 14)
      return 16'h0020;
    else if (idx == 27)
      return 16'h000f;
    else
      return 16'h0000;
  endfunction : reg_default

  typedef enum logic [1:0] {SRPDM_LOAD, SRPDM_RUN, SRPDM_SAVE} srpdm_state_e;

endpackage : srpdm_pkg

// file: rtl/srpdm_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module srpdm_sync #(
  parameter int         WIDTH    = 4,
  parameter logic [3:0] IDLE_VAL = 4'h0
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_pinSync;

  // ----------------------------------------------------------------------------
  // Per-bit pipeline
  // ----------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_stage1[i]  = pinIn[i];
        next_pinSync[i] = stage1[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1  <= IDLE_VAL[WIDTH-1:0];
      pinSync <= IDLE_VAL[WIDTH-1:0];
    end else begin
      stage1  <= next_stage1;
      pinSync <= next_pinSync;
    end
  end

endmodule : srpdm_sync

// file: rtl/srpdm_core.sv
// Serial register port with working registers, backup copy and sample capture
`timescale 1ns/1ps
module srpdm_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        rstPinN,
  input  wire logic        spiSclk,
  input  wire logic        spiCsN,
  input  wire logic        spiDin,
  output logic             spiDout,
  output logic             spiDoutOe,
  input  wire logic        sampleValid,
  input  wire logic [15:0] sampleX,
  input  wire logic [15:0] sampleY,
  input  wire logic [15:0] sampleZ,
  output logic             dataEnable,
  output logic             alarm,
  output logic             stallViolation
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic [3:0] pinSync;
  logic       sclkS;
  logic       csNS;
  logic       dinS;
  logic       rstNS;

  srpdm_sync #(
    .WIDTH    (4),
    .IDLE_VAL (4'hb)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   ({rstPinN, spiDin, spiCsN, spiSclk}),
    .pinSync (pinSync)
  );

  assign sclkS = pinSync[0];
  assign csNS  = pinSync[1];
  assign dinS  = pinSync[2];
  assign rstNS = pinSync[3];

  // Enable comes straight from the pin so the line floats without sync lag
  assign spiDoutOe = ~spiCsN;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  srpdm_pkg::srpdm_state_e state;
  srpdm_pkg::srpdm_state_e next_state;

  logic [15:0] sram  [srpdm_pkg::REG_COUNT];
  logic [15:0] flash [srpdm_pkg::REG_COUNT];
  logic [15:0] next_sram  [srpdm_pkg::REG_COUNT];
  logic [15:0] next_flash [srpdm_pkg::REG_COUNT];

  logic        sclkPrev;
  logic [3:0]  bitCnt;
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic        doutBit;
  logic [4:0]  walkIdx;
  logic [11:0] stallCnt;
  logic        stallFlag;
  logic        next_sclkPrev;
  logic [3:0]  next_bitCnt;
  logic [15:0] next_rxShift;
  logic [15:0] next_txShift;
  logic        next_doutBit;
  logic [4:0]  next_walkIdx;
  logic [11:0] next_stallCnt;
  logic        next_stallFlag;

  logic        sclkRise;
  logic        sclkFall;
  logic [15:0] frame;
  logic        frameDone;
  logic [4:0]  frIdx;
  logic        frUpper;
  logic        frUnmapped;

  // Frame edges count only while selected
  assign sclkRise   = sclkS & ~sclkPrev & ~csNS;
  assign sclkFall   = ~sclkS & sclkPrev & ~csNS;
  assign frame      = {rxShift[14:0], dinS};
  assign frameDone  = sclkRise && (bitCnt == srpdm_pkg::BIT_LAST);
  assign frIdx      = frame[srpdm_pkg::FR_IDX_HI:srpdm_pkg::FR_IDX_LO];
  assign frUpper    = frame[srpdm_pkg::FR_BYTE_SEL];
  assign frUnmapped = frame[srpdm_pkg::FR_ADDR_HI];

  assign spiDout        = doutBit;
  assign dataEnable     = (state == srpdm_pkg::SRPDM_RUN);
  assign stallViolation = stallFlag;
  assign alarm          = |sram[srpdm_pkg::IDX_DIAG][2:0];

  // ----------------------------------------------------------------------------
  // Sample processing
  // ----------------------------------------------------------------------------
  logic signed [15:0] axisIn  [3];
  logic signed [15:0] axisOut [3];

  assign axisIn[0] = sampleX;
  assign axisIn[1] = sampleY;
  assign axisIn[2] = sampleZ;

  generate
    for (genvar a = 0; a < 3; a++) begin : g_axis
      logic signed [16:0] adj;
      logic signed [16:0] avg;
      always_comb begin
        adj = 17'(axisIn[a]) + 17'($signed(sram[srpdm_pkg::IDX_OFFS_X + 5'(a)]));
        avg = (adj + 17'($signed(sram[srpdm_pkg::IDX_BUFF_X + 5'(a)]))) >>> 1;
        // Two-point average as the light filter when averaging is on
        if (sram[srpdm_pkg::IDX_AVG] != 16'h0000)
          axisOut[a] = avg[15:0];
        else
          axisOut[a] = adj[15:0];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [15:0] wr;
    wr             = 16'h0000;
    next_state     = state;
    next_sram      = sram;
    next_flash     = flash;
    next_sclkPrev  = sclkS;
    next_bitCnt    = bitCnt;
    next_rxShift   = rxShift;
    next_txShift   = txShift;
    next_doutBit   = doutBit;
    next_walkIdx   = walkIdx;
    next_stallFlag = 1'b0;
    next_stallCnt  = (stallCnt != 12'h000) ? stallCnt - 12'h001 : stallCnt;

    // Serial shifting
    if (csNS) begin
      next_bitCnt = 4'h0;
    end else begin
      if (sclkRise) begin
        next_rxShift = frame;
        next_bitCnt  = bitCnt + 4'h1;
        if (bitCnt == 4'h0 && stallCnt != 12'h000)
          next_stallFlag = 1'b1;
      end
      if (sclkFall) begin
        next_doutBit = txShift[15];
        next_txShift = {txShift[14:0], 1'b0};
      end
    end

    // Sample capture; alarms are sticky until the status register is read
    if (sampleValid && state == srpdm_pkg::SRPDM_RUN) begin
      for (int a = 0; a < 3; a++) begin
        next_sram[srpdm_pkg::IDX_BUFF_X + 5'(a)] = axisOut[a];
        if (axisOut[a] > $signed(sram[srpdm_pkg::IDX_PEAK_X + 5'(a)]))
          next_sram[srpdm_pkg::IDX_PEAK_X + 5'(a)] = axisOut[a];
      end
    end

    // Frame handling
    if (frameDone) begin
      next_stallCnt = 12'(srpdm_pkg::STALL_CYCLES);
      next_txShift  = 16'h0000;
      if (!frame[srpdm_pkg::FR_RW]) begin
        if (!frUnmapped && frIdx != srpdm_pkg::IDX_GLOBAL_COMMAND_REG) begin
          next_txShift = sram[frIdx];
          if (frIdx == srpdm_pkg::IDX_DIAG)
            next_sram[srpdm_pkg::IDX_DIAG][2:0] = 3'h0;
        end
      end else if (!frUnmapped && state == srpdm_pkg::SRPDM_RUN) begin
        wr = frUpper ? {frame[7:0], 8'h00} : {8'h00, frame[7:0]};
        if (frIdx == srpdm_pkg::IDX_GLOBAL_COMMAND_REG) begin
          if (wr[srpdm_pkg::CMD_SAVE_BIT]) begin
            next_state   = srpdm_pkg::SRPDM_SAVE;
            next_walkIdx = 5'h00;
          end else if (wr[srpdm_pkg::CMD_RELOAD_BIT]) begin
            next_state   = srpdm_pkg::SRPDM_LOAD;
            next_walkIdx = 5'h00;
          end
        end else if (srpdm_pkg::WRITE_MASK[frIdx]) begin
          if (frUpper)
            next_sram[frIdx][15:8] = frame[7:0];
          else
            next_sram[frIdx][7:0] = frame[7:0];
        end
      end
    end

    // Alarm checks after any clear so that a new event wins
    if (sampleValid && state == srpdm_pkg::SRPDM_RUN) begin
      for (int a = 0; a < 3; a++) begin
        if (sram[srpdm_pkg::IDX_ALM_X + 5'(a)] != 16'h0000 &&
            axisOut[a] > $signed(sram[srpdm_pkg::IDX_ALM_X + 5'(a)]))
          next_sram[srpdm_pkg::IDX_DIAG][a] = 1'b1;
      end
    end

    // Walks between the two copies
    unique case (state)
      srpdm_pkg::SRPDM_LOAD: begin
        if (srpdm_pkg::BACKUP_MASK[walkIdx])
          next_sram[walkIdx] = flash[walkIdx];
        else
          next_sram[walkIdx] = srpdm_pkg::reg_default(int'(walkIdx));
        next_walkIdx = walkIdx + 5'h01;
        if (walkIdx == 5'h1f)
          next_state = srpdm_pkg::SRPDM_RUN;
      end
      srpdm_pkg::SRPDM_SAVE: begin
        if (srpdm_pkg::BACKUP_MASK[walkIdx] && walkIdx != srpdm_pkg::IDX_FLASH_CNT)
          next_flash[walkIdx] = sram[walkIdx];
        next_walkIdx = walkIdx + 5'h01;
        if (walkIdx == 5'h1f) begin
          next_flash[srpdm_pkg::IDX_FLASH_CNT] = flash[srpdm_pkg::IDX_FLASH_CNT] + 16'h0001;
          next_sram[srpdm_pkg::IDX_FLASH_CNT]  = flash[srpdm_pkg::IDX_FLASH_CNT] + 16'h0001;
          next_state = srpdm_pkg::SRPDM_RUN;
        end
      end
      srpdm_pkg::SRPDM_RUN: begin
      end
    endcase

    // Reset pin drops the frame and restarts the reload until it is released
    if (!rstNS) begin
      next_bitCnt  = 4'h0;
      next_txShift = 16'h0000;
      next_doutBit = 1'b0;
      next_state   = srpdm_pkg::SRPDM_LOAD;
      next_walkIdx = 5'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= srpdm_pkg::SRPDM_LOAD;
      sclkPrev  <= 1'b1;
      bitCnt    <= 4'h0;
      rxShift   <= 16'h0000;
      txShift   <= 16'h0000;
      doutBit   <= 1'b0;
      walkIdx   <= 5'h00;
      stallCnt  <= 12'h000;
      stallFlag <= 1'b0;
      for (int i = 0; i < srpdm_pkg::REG_COUNT; i++) begin
        sram[i]  <= srpdm_pkg::reg_default(i);
        flash[i] <= srpdm_pkg::reg_default(i);
      end
    end else begin
      state     <= next_state;
      sclkPrev  <= next_sclkPrev;
      bitCnt    <= next_bitCnt;
      rxShift   <= next_rxShift;
      txShift   <= next_txShift;
      doutBit   <= next_doutBit;
      walkIdx   <= next_walkIdx;
      stallCnt  <= next_stallCnt;
      stallFlag <= next_stallFlag;
      sram      <= next_sram;
      flash     <= next_flash;
    end
  end

endmodule : srpdm_core

// file: verification/srpdm_core_assertions.sv
// Concurrent checks on the ports of the serial register port
`timescale 1ns/1ps
module srpdm_core_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        rstPinN,
  input wire logic        spiSclk,
  input wire logic        spiCsN,
  input wire logic        spiDin,
  input wire logic        spiDout,
  input wire logic        spiDoutOe,
  input wire logic        sampleValid,
  input wire logic [15:0] sampleX,
  input wire logic [15:0] sampleY,
  input wire logic [15:0] sampleZ,
  input wire logic        dataEnable,
  input wire logic        alarm,
  input wire logic        stallViolation
);
  default clocking cb @(posedge clk); endclocking
  chk_oe_follows_cs: assert property (disable iff (sys_rst) spiDoutOe == !spiCsN)
    else $error("output enable differs from chip select");
  chk_reset_quiet: assert property (sys_rst |=> !spiDout && !alarm && !stallViolation)
    else $error("outputs active after reset");
  chk_reload_boot: assert property (disable iff (sys_rst) $fell(sys_rst) |-> !dataEnable[*8] ##[20:48] dataEnable)
    else $error("reload after reset has wrong length");
  chk_pin_hold: assert property (disable iff (sys_rst) !rstPinN[*4] |=> !dataEnable)
    else $error("running while reset pin low");
  chk_pin_reload: assert property (disable iff (sys_rst) $rose(rstPinN) |-> ##[28:50] dataEnable)
    else $error("no reload after reset pin release");
  chk_dout_on_fall: assert property (disable iff (sys_rst)
    $changed(spiDout) && rstPinN && $past(rstPinN, 4) |-> !spiSclk)
    else $error("serial output moved while clock high");
  chk_stall_pulse: assert property (disable iff (sys_rst) stallViolation |-> !spiCsN ##1 !stallViolation)
    else $error("stall flag outside frame or too long");
  chk_enable_drop: assert property (disable iff (sys_rst)
    $fell(dataEnable) |-> !spiCsN || !rstPinN || !$past(rstPinN, 3) || !$past(rstPinN, 4))
    else $error("run state left without cause");
endmodule : srpdm_core_assertions

bind srpdm_core srpdm_core_assertions chk_u (
  .clk(clk), .sys_rst(sys_rst), .rstPinN(rstPinN), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiDin(spiDin),
  .spiDout(spiDout), .spiDoutOe(spiDoutOe), .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY),
  .sampleZ(sampleZ), .dataEnable(dataEnable), .alarm(alarm), .stallViolation(stallViolation)
);

// file: verification/srpdm_spi_master.sv
// Mode 3 serial master that drives the port from the far side
`timescale 1ns/1ps
module srpdm_spi_master (
  input  wire logic spiDout,
  input  wire logic spiDoutOe,
  output logic      spiSclk,
  output logic      spiCsN,
  output logic      spiDin
);
  logic lastDout = 1'b0;
  logic doutLine;
  // A floating line must not repeat the last bit
  assign doutLine = spiDoutOe ? spiDout : ~lastDout;
  initial begin
    spiSclk = 1'b1;
    spiCsN  = 1'b1;
    spiDin  = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input bit shortGap, output logic [15:0] rx);
    spiCsN = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      spiSclk = 1'b0;
      spiDin  = tx[i];
      #62.5;
      spiSclk  = 1'b1;
      rx[i]    = doutLine;
      lastDout = doutLine;
      #62.5;
    end
    spiCsN = 1'b1;
    spiDin = ~tx[0];
    #(shortGap ? 1000.0 : 15500.0);
  endtask : xfer
endmodule : srpdm_spi_master

// file: verification/tb.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic        rstPinN = 1'b1;
  logic        sampleValid = 1'b0;
  logic [15:0] sampleX = 16'h0000;
  logic [15:0] sampleY = 16'h0000;
  logic [15:0] sampleZ = 16'h0000;
  logic        spiSclk, spiCsN, spiDin, spiDout, spiDoutOe;
  logic        dataEnable, alarm, stallViolation;
  logic [15:0] rx, offs, smp;
  int          miscompares = 0;
  int          checksDone = 0;
  int          cycles = 0;
  int          stallCnt = 0;

  always #2 clk = ~clk;

  srpdm_core dut_u (.clk(clk), .sys_rst(sysRst), .rstPinN(rstPinN), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiDin(spiDin), .spiDout(spiDout), .spiDoutOe(spiDoutOe), .sampleValid(sampleValid), .sampleX(sampleX),
    .sampleY(sampleY), .sampleZ(sampleZ), .dataEnable(dataEnable), .alarm(alarm), .stallViolation(stallViolation));
  srpdm_spi_master master_u (.spiDout(spiDout), .spiDoutOe(spiDoutOe), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiDin(spiDin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] wrFrame(input logic [6:0] addr, input logic [7:0] data);
    return {1'b1, addr, data};
  endfunction : wrFrame
  function automatic logic [15:0] rdFrame(input logic [6:0] addr);
    return {1'b0, addr, 8'h00};
  endfunction : rdFrame
  task automatic check(input string what, input logic [15:0] expVal, input logic [15:0] seen);
    checksDone++;
    if (seen !== expVal) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, expVal, seen);
    end
  endtask : check
  task automatic waitEnable();
    int n;
    n = 0;
    while (dataEnable !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("dataEnable", 16'h0001, {15'h0000, dataEnable});
  endtask : waitEnable
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short after about twenty-one and a half long-gap frames' worth of time
  always @(posedge clk) begin
    cycles++;
    if (stallViolation === 1'b1) begin
      stallCnt++;
    end
    if (cycles == 95000) begin
      miscompares++;
      $display("MISMATCH timeout expected finish seen hang");
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'ha35bbae3));
    repeat (6) @(posedge clk);
    #1 sysRst = 1'b0;
    waitEnable();
    $display("Test reset done");
    offs = 16'($urandom);
    smp  = 16'($urandom);
    master_u.xfer(wrFrame(7'h02, offs[7:0]), 1'b0, rx);
    master_u.xfer(wrFrame(7'h03, offs[15:8]), 1'b0, rx);
    check("after write", 16'h0000, rx);
    @(posedge clk);
    #1 {sampleX, sampleY, sampleZ, sampleValid} = {smp, 16'($urandom), 16'($urandom), 1'b1};
    @(posedge clk);
    #1 sampleValid = 1'b0;
    master_u.xfer(rdFrame(7'h02), 1'b0, rx);
    master_u.xfer(wrFrame(7'h14, 8'h5a), 1'b0, rx);
    check("offset", offs, rx);
    master_u.xfer(rdFrame(7'h14), 1'b0, rx);
    master_u.xfer(16'hbf10, 1'b0, rx);
    check("buffer", smp + offs, rx);
    $display("Test write and capture done");
    waitEnable();
    master_u.xfer(wrFrame(7'h02, ~offs[7:0]), 1'b0, rx);
    master_u.xfer(rdFrame(7'h02), 1'b0, rx);
    master_u.xfer(rdFrame(7'h00), 1'b0, rx);
    check("working copy", {offs[15:8], ~offs[7:0]}, rx);
    $display("Test save done");
    @(posedge clk);
    #1 rstPinN = 1'b0;
    repeat (10) @(posedge clk);
    #1 rstPinN = 1'b1;
    waitEnable();
    master_u.xfer(rdFrame(7'h02), 1'b0, rx);
    master_u.xfer(rdFrame(7'h00), 1'b0, rx);
    check("reloaded offset", offs, rx);
    master_u.xfer(rdFrame(7'h14), 1'b0, rx);
    check("save count", 16'h0001, rx);
    master_u.xfer(rdFrame(7'h00), 1'b1, rx);
    check("unbacked default", 16'h8000, rx);
    $display("Test reload done");
    check("stall pulses", 16'h0000, 16'(stallCnt));
    master_u.xfer(rdFrame(7'h00), 1'b0, rx);
    check("read during stall", 16'h0001, rx);
    check("stall pulses", 16'h0001, 16'(stallCnt));
    $display("Test stall done");
    master_u.xfer(wrFrame(7'h20, 8'h01), 1'b0, rx);
    @(posedge clk);
    #1 {sampleX, sampleValid} = {16'h4000 - offs, 1'b1};
    @(posedge clk);
    #1 sampleValid = 1'b0;
    check("alarm set", 16'h0001, {15'h0000, alarm});
    master_u.xfer(rdFrame(7'h3c), 1'b0, rx);
    check("alarm cleared", 16'h0000, {15'h0000, alarm});
    master_u.xfer(16'hbe80, 1'b0, rx);
    check("alarm status", 16'h0001, rx);
    waitEnable();
    master_u.xfer(rdFrame(7'h20), 1'b0, rx);
    master_u.xfer(rdFrame(7'h00), 1'b0, rx);
    check("reload command", 16'h0000, rx);
    $display("Test alarm and reload command done");
    tally_and_finish();
  end
endmodule : tb
